// >>> rtl/hrw_pkg.sv
// Purpose: Shared constants of the hibernation RTC and wake block
// Assumes: APB, 32-bit data, byte addresses
// Notes:   Offsets, field positions and reset values
package hrw_pkg;
   localparam logic [11:0] OFF_CTRL     = 12'h000;
   localparam logic [11:0] OFF_SECONDS  = 12'h004;
   localparam logic [11:0] OFF_MATCH    = 12'h008;
   localparam logic [11:0] OFF_SUBSEC   = 12'h00c;
   localparam logic [11:0] OFF_SUBMATCH = 12'h010;
   localparam logic [11:0] OFF_TRIM     = 12'h014;
   localparam logic [11:0] OFF_RAWSTAT  = 12'h018;
   localparam logic [11:0] OFF_MASK     = 12'h01c;
   localparam logic [11:0] OFF_MASKSTAT = 12'h020;
   localparam logic [11:0] OFF_STATUS   = 12'h024;

   localparam int CTRL_RTC_EN   = 0;
   localparam int CTRL_WAKE_PIN = 1;
   localparam int CTRL_WAKE_RTC = 2;
   localparam int CTRL_HIB_REQ  = 3;

   localparam int EV_RTC_MATCH  = 0;
   localparam int EV_PIN_WAKE   = 1;
   localparam int EV_W          = 2;

   localparam int ST_REG_ON     = 0;
   localparam int ST_HIBERNATE  = 1;

   localparam int SUB_W         = 15;
   localparam int PREDIV_W      = 16;
   localparam logic [PREDIV_W-1:0] TRIM_NOMINAL = 16'h7fff;
   localparam logic [PREDIV_W-1:0] PREDIV_RESET = 16'h0000;
   localparam logic [5:0]  TRIM_PERIOD_SEC = 6'h3f;
   localparam logic [31:0] SECONDS_RESET   = 32'h0000_0000;
   localparam logic [31:0] MATCH_RESET     = 32'hffff_ffff;
   localparam logic [SUB_W-1:0] SUBMATCH_RESET = 15'h0000;
endpackage : hrw_pkg

// >>> rtl/hrw_rtc_wake.sv
// Purpose: Always-on RTC with match, trim and wake control, APB slave
// Assumes: 32768 Hz time source and wake pin asynchronous to pclk
// Notes:   One wait state on every APB access
//
// Functional notes
// - Seconds counter advances once per second from the divided time source.
// - Readable sub-second count in 1/32768 s units runs beside seconds.
// - Seconds match compare raises interrupt and/or wake as configured.
// - Match fires only when seconds and sub-second match both equal time.
// - Predivider divides the time source into a one-second tick.
// - Trim value is applied to the predivider once every 64 seconds.
// - Trim register readable and writable, nominal value 0x7fff.
// - Pin and RTC wake enables are independent and readable.
// - With pin wake enabled, asserted wake input ends hibernation.
// - With RTC wake enabled, an RTC match ends hibernation.
// - Hibernate request turns regulator off; enabled wake turns it on.
`timescale 1ns/1ns
`default_nettype none
module hrw_rtc_wake (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   input  wire logic        clk32_in,
   input  wire logic        wake_pin,
   output var  logic        regulator_en,
   output var  logic        irq
);
   import hrw_pkg::*;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = (a == off);
   endfunction : hit

   ////////////////////////////////////////////////////////////////////
   // APB decode
   logic        pready_reg;
   logic        pslverr_reg;
   logic [31:0] prdata_reg;
   logic [31:0] rdata_next;
   logic        mapped;
   // First access cycle; the one after it carries the answer
   wire         acc_first = psel & penable & ~pready_reg;
   wire         acc     = psel & penable & pready_reg;
   wire         wr      = acc & pwrite;
   wire         wr_ctrl = wr & hit(paddr, OFF_CTRL);
   wire         wr_sec  = wr & hit(paddr, OFF_SECONDS);
   wire         wr_mat  = wr & hit(paddr, OFF_MATCH);
   wire         wr_smat = wr & hit(paddr, OFF_SUBMATCH);
   wire         wr_trim = wr & hit(paddr, OFF_TRIM);
   wire         wr_raw  = wr & hit(paddr, OFF_RAWSTAT);
   wire         wr_mask = wr & hit(paddr, OFF_MASK);

   ////////////////////////////////////////////////////////////////////
   // State
   logic                rtc_en_reg;
   logic                wake_on_pin_enable_reg;
   logic                wake_on_rtc_match_enable_reg;
   logic                hibernate_reg;
   logic                regulator_en_reg;
   logic [31:0]         seconds_reg;
   logic [31:0]         match_reg;
   logic [SUB_W-1:0]    submatch_reg;
   logic [PREDIV_W-1:0] trim_reg;
   logic [PREDIV_W-1:0] prediv_reg;
   logic [EV_W-1:0]     raw_reg;
   logic [EV_W-1:0]     mask_reg;
   logic                irq_reg;
   logic                eq_d_reg;
   logic [2:0]          clk32_sync_reg;
   logic [2:0]          pin_sync_reg;

   ////////////////////////////////////////////////////////////////////
   // Time source and pin synchronisers
   // Bit 0 feeds only bit 1; edges are taken from bits 1 and 2
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk32_sync_reg <= 3'h0;
      end else begin
         clk32_sync_reg <= {clk32_sync_reg[1:0], clk32_in};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_sync_reg <= 3'h0;
      end else begin
         pin_sync_reg <= {pin_sync_reg[1:0], wake_pin};
      end
   end

   wire tick32    = clk32_sync_reg[1] & ~clk32_sync_reg[2];
   wire pin_level = pin_sync_reg[1];
   wire pin_rise  = pin_sync_reg[1] & ~pin_sync_reg[2];

   ////////////////////////////////////////////////////////////////////
   // Predivider and counters
   // Trim takes the place of the nominal terminal count once per 64 s
   wire [PREDIV_W-1:0] prediv_limit =
      (seconds_reg[5:0] == TRIM_PERIOD_SEC) ? trim_reg : TRIM_NOMINAL;
   wire sec_tick = rtc_en_reg & tick32 & (prediv_reg >= prediv_limit);
   wire [PREDIV_W-1:0] prediv_next =
      wr_sec   ? PREDIV_RESET :
      sec_tick ? PREDIV_RESET :
      (rtc_en_reg & tick32) ? prediv_reg + 16'h0001 : prediv_reg;
   wire [31:0] seconds_next =
      wr_sec   ? pwdata :
      sec_tick ? seconds_reg + 32'h0000_0001 : seconds_reg;

   ////////////////////////////////////////////////////////////////////
   // Match and events
   // Compare on both fields so a match lands on one sub-second step
   wire time_eq  = (seconds_reg == match_reg) &
                   (prediv_reg[SUB_W-1:0] == submatch_reg);
   wire match_ev = rtc_en_reg & time_eq & ~eq_d_reg;
   wire [EV_W-1:0] ev_set = {pin_rise, match_ev};
   wire [EV_W-1:0] ev_clr = wr_raw ? pwdata[EV_W-1:0] : '0;
   // An event in the clearing cycle survives the clear
   wire [EV_W-1:0] raw_next  = (raw_reg & ~ev_clr) | ev_set;
   wire [EV_W-1:0] mask_next = wr_mask ? pwdata[EV_W-1:0] : mask_reg;
   wire            irq_next  = |(raw_next & mask_next);

   ////////////////////////////////////////////////////////////////////
   // Wake control
   wire wake_now = (wake_on_pin_enable_reg & pin_level)
                 | (wake_on_rtc_match_enable_reg & match_ev);
   wire hib_req  = wr_ctrl & pwdata[CTRL_HIB_REQ];
   // A pending wake condition cancels the request rather than losing it
   wire hibernate_next = wake_now ? 1'b0 :
                         hib_req  ? 1'b1 : hibernate_reg;

   ////////////////////////////////////////////////////////////////////
   // Read mux
   always_comb begin
      rdata_next = 32'h0000_0000;
      mapped     = 1'b1;
      unique case (paddr)
         OFF_CTRL: begin
            rdata_next[CTRL_RTC_EN]   = rtc_en_reg;
            rdata_next[CTRL_WAKE_PIN] = wake_on_pin_enable_reg;
            rdata_next[CTRL_WAKE_RTC] = wake_on_rtc_match_enable_reg;
         end
         OFF_SECONDS:  rdata_next = seconds_reg;
         OFF_MATCH:    rdata_next = match_reg;
         OFF_SUBSEC:   rdata_next[SUB_W-1:0] = prediv_reg[SUB_W-1:0];
         OFF_SUBMATCH: rdata_next[SUB_W-1:0] = submatch_reg;
         OFF_TRIM:     rdata_next[PREDIV_W-1:0] = trim_reg;
         OFF_RAWSTAT:  rdata_next[EV_W-1:0] = raw_reg;
         OFF_MASK:     rdata_next[EV_W-1:0] = mask_reg;
         OFF_MASKSTAT: rdata_next[EV_W-1:0] = raw_reg & mask_reg;
         OFF_STATUS: begin
            rdata_next[ST_REG_ON]    = ~hibernate_reg;
            rdata_next[ST_HIBERNATE] = hibernate_reg;
         end
         default:      mapped = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // APB answer: one wait state, data and error registered
   // Data is zero outside a read answer, so no stale word leaks out
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
      end else begin
         pready_reg <= acc_first;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr_reg <= 1'b0;
      end else begin
         pslverr_reg <= acc_first & ~mapped;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0000_0000;
      end else begin
         prdata_reg <= (acc_first & ~pwrite) ? rdata_next : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rtc_en_reg                   <= 1'b0;
         wake_on_pin_enable_reg       <= 1'b0;
         wake_on_rtc_match_enable_reg <= 1'b0;
      end else if (wr_ctrl) begin
         rtc_en_reg                   <= pwdata[CTRL_RTC_EN];
         wake_on_pin_enable_reg       <= pwdata[CTRL_WAKE_PIN];
         wake_on_rtc_match_enable_reg <= pwdata[CTRL_WAKE_RTC];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         match_reg <= MATCH_RESET;
      end else if (wr_mat) begin
         match_reg <= pwdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         submatch_reg <= SUBMATCH_RESET;
      end else if (wr_smat) begin
         submatch_reg <= pwdata[SUB_W-1:0];
      end
   end

   // Takes effect in the next second 63 of the count, not at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trim_reg <= TRIM_NOMINAL;
      end else if (wr_trim) begin
         trim_reg <= pwdata[PREDIV_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Time, events and power
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seconds_reg <= SECONDS_RESET;
      end else begin
         seconds_reg <= seconds_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prediv_reg <= PREDIV_RESET;
      end else begin
         prediv_reg <= prediv_next;
      end
   end

   // Delayed equality turns the match into a one-cycle event
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         eq_d_reg <= 1'b0;
      end else begin
         eq_d_reg <= time_eq;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         raw_reg <= '0;
      end else begin
         raw_reg <= raw_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_reg <= '0;
      end else begin
         mask_reg <= mask_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= irq_next;
      end
   end

   // Own flop for the regulator pin, so no inverter sits behind it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hibernate_reg    <= 1'b0;
         regulator_en_reg <= 1'b1;
      end else begin
         hibernate_reg    <= hibernate_next;
         regulator_en_reg <= ~hibernate_next;
      end
   end

   assign prdata       = prdata_reg;
   assign pready       = pready_reg;
   assign pslverr      = pslverr_reg;
   assign irq          = irq_reg;
   assign regulator_en = regulator_en_reg;
endmodule : hrw_rtc_wake
`default_nettype wire

// >>> verification/hrw_checker.sv
// Purpose: APB and wake assertions for the RTC wake block
// Assumes: one pclk domain, presetn active low
// Notes:   Sees only the block's ports
`timescale 1ns/1ns
`default_nettype none
module hrw_checker
   import hrw_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        regulator_en,
   input wire logic        irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic unmapped = paddr > OFF_STATUS || paddr[1:0] != 2'h0;
   sequence s_wr(a);
      psel && penable && pready && pwrite && paddr == a;
   endsequence
   ////////////////////////////////////////
   ready_pulse_a:
      assert property (pready |=> !pready) else $error("ready too long");
   wait_state_a:
      assert property (psel && penable && !pready |=> pready) else $error("ready late");
   ready_cause_a:
      assert property (pready |-> $past(psel && penable)) else $error("ready unasked");
   bus_idle_a:
      assert property (!pready |-> prdata == 32'h0 && !pslverr) else $error("bus not idle");
   err_decode_a:
      assert property (pready |-> pslverr == unmapped) else $error("wrong error");
   hib_off_a:
      assert property (s_wr(OFF_CTRL) ##0 pwdata[3:1] == 3'h4 |=> !regulator_en)
         else $error("regulator stays on");
   mask_clear_a:
      assert property (s_wr(OFF_MASK) ##0 pwdata[1:0] == 2'h0 |=> !irq) else $error("irq");
   status_mirror_a:
      assert property (pready && !pwrite && paddr == OFF_STATUS |->
         prdata[1:0] == {!$past(regulator_en), $past(regulator_en)}) else $error("status");
endmodule : hrw_checker
bind hrw_rtc_wake hrw_checker i_chk (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .pslverr, .regulator_en, .irq
);
`default_nettype wire

// >>> verification/hrw_far_side.sv
// Purpose: Far side model: time source and wake switch
// Assumes: one rising time source edge per 16 pclk
// Notes:   Sped up; the block counts edges, so only run length changes
`timescale 1ns/1ns
`default_nettype none
module hrw_far_side (
   input  wire logic pclk,
   input  wire logic wake_req,
   output var  logic clk32_in,
   output var  logic wake_pin
);
   logic [2:0] div_reg = 3'h0;
   initial clk32_in = 1'b0;
   initial wake_pin = 1'b0;
   always @(posedge pclk) begin
      div_reg <= div_reg + 3'h1;
      if (div_reg == 3'h7) clk32_in <= ~clk32_in;
      wake_pin <= wake_req;
   end
endmodule : hrw_far_side
`default_nettype wire

// >>> verification/tb_hibernation_rtc_wake.sv
// Purpose: Self-checking bench for the RTC wake block
// Assumes: fast time source from the far side model
// Notes:   One task per scenario; shared APB tasks
`timescale 1ns/1ns
`default_nettype none
module tb_hibernation_rtc_wake;
   import hrw_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, wake_req;
   logic        pready, pslverr, clk32_in, wake_pin, regulator_en, irq, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r, s;
   int          mismatches, total_checks;
   hrw_rtc_wake i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .clk32_in, .wake_pin, .regulator_en, .irq);
   hrw_far_side i_far (.pclk, .wake_req, .clk32_in, .wake_pin);
   ////////////////////////////////////////
   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : stop_test
   task automatic chk(input string n, input logic [31:0] g, input logic [31:0] x);
      total_checks++;
      if (g !== x) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", n, x, g);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         mismatches++;
         stop_test();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic rc(input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), r, x);
   endtask : rc
   // Bounded wait for the regulator to reach a level
   task automatic wt(input logic want);
      int n;
      for (n = 0; n < 300 && regulator_en !== want; n++) @(posedge pclk);
      chk("regulator", 32'(regulator_en), 32'(want));
      if (n == 300) stop_test();
   endtask : wt
   ////////////////////////////////////////
   task automatic t_reset;
      rc(OFF_CTRL, 32'h0);
      rc(OFF_MATCH, MATCH_RESET);
      rc(OFF_TRIM, 32'(TRIM_NOMINAL));
      rc(OFF_STATUS, 32'h1);
      apb(1'b1, 12'h028, 32'h1);
      rc(12'h028, 32'h0);
      chk("unmapped", 32'(e), 32'h1);
   endtask : t_reset
   task automatic t_regs;
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, OFF_CTRL, 32'(i * 2));
         rc(OFF_CTRL, 32'(i * 2));
      end
      apb(1'b1, OFF_TRIM, 32'h8001);
      rc(OFF_TRIM, 32'h8001);
      apb(1'b1, OFF_SUBMATCH, 32'hffff);
      rc(OFF_SUBMATCH, 32'h7fff);
      apb(1'b1, OFF_MATCH, 32'h40);
      rc(OFF_MATCH, 32'h40);
   endtask : t_regs
   // Short trim at second 63 gives a fast tick; the next second is nominal
   task automatic t_tick;
      apb(1'b1, OFF_CTRL, 32'h1);
      apb(1'b1, OFF_TRIM, 32'h3);
      apb(1'b1, OFF_SECONDS, 32'h3f);
      for (int n = 0; n < 60 && r !== 32'h40; n++) apb(1'b0, OFF_SECONDS, 32'h0);
      chk("tick", r, 32'h40);
      apb(1'b0, OFF_SUBSEC, 32'h0);
      s = r;
      repeat (64) @(posedge pclk);
      apb(1'b0, OFF_SUBSEC, 32'h0);
      chk("subsec step", 32'(r - s > 3 && r - s < 6), 32'h1);
      rc(OFF_SECONDS, 32'h40);
   endtask : t_tick
   task automatic t_match;
      apb(1'b1, OFF_SUBMATCH, 32'h2);
      apb(1'b1, OFF_MASK, 32'h1);
      apb(1'b1, OFF_CTRL, 32'h5);
      apb(1'b1, OFF_SECONDS, 32'h3f);
      apb(1'b1, OFF_CTRL, 32'hd);
      chk("asleep", 32'(regulator_en), 32'h0);
      wt(1'b1);
      rc(OFF_SUBSEC, 32'h2);
      rc(OFF_SECONDS, 32'h40);
      chk("irq set", 32'(irq), 32'h1);
      apb(1'b1, OFF_RAWSTAT, 32'h1);
      chk("irq clr", 32'(irq), 32'h0);
   endtask : t_match
   task automatic t_pin;
      apb(1'b1, OFF_MASK, 32'h0);
      apb(1'b1, OFF_CTRL, 32'h9);
      wake_req <= 1'b1;
      repeat (20) @(posedge pclk);
      chk("pin gated", 32'(regulator_en), 32'h0);
      rc(OFF_RAWSTAT, 32'h2);
      rc(OFF_STATUS, 32'h2);
      chk("irq masked", 32'(irq), 32'h0);
      apb(1'b1, OFF_CTRL, 32'h3);
      wt(1'b1);
      apb(1'b1, OFF_MASK, 32'h2);
      chk("irq pin", 32'(irq), 32'h1);
      rc(OFF_MASKSTAT, 32'h2);
      wake_req <= 1'b0;
   endtask : t_pin
   ////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   initial begin
      {presetn, psel, penable, pwrite, wake_req} = 5'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      mismatches = 0;
      total_checks = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_regs();
      t_tick();
      t_match();
      t_pin();
      stop_test();
   end
endmodule : tb_hibernation_rtc_wake
`default_nettype wire
